// ===== design/iob_pkg.sv
// Constants and types shared by the I/O bus device interface
package iob_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam logic [7:0]  REG_CONFIG    = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_BUFFER    = 8'h08;
	localparam logic [31:0] CONFIG_RST    = 32'h0000_0001;

	// Config fields
	localparam int CFG_ADDR_LSB  = 0;
	localparam int CFG_MBIT_LSB  = 8;
	localparam int CFG_MBIT_W    = 4;
	localparam int CFG_NO_READY  = 16;
	localparam int CFG_BLOCK     = 17;
	localparam int CFG_PARITY_EN = 18;

	// Status fields
	localparam int ST_READY      = 0;
	localparam int ST_BUSY       = 1;
	localparam int ST_MASK       = 2;
	localparam int ST_DIR        = 3;
	localparam int ST_CHAN_EN    = 4;
	localparam int ST_CHAN_READY = 5;
	localparam int ST_INT_FLAG   = 6;
	localparam int ST_OVERRUN    = 7;
	localparam int ST_CHAN_REQ   = 8;
	localparam int ST_BLOCK_STOP = 9;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_DECERR   = 2'h3;

	// ********************************
	// Control and skip function codes
	// ********************************
	localparam logic [3:0]  FN_WRITE      = 4'h1;
	localparam logic [3:0]  FN_READ       = 4'h2;
	localparam logic [3:0]  FN_CHAN_ON    = 4'h3;
	localparam logic [3:0]  FN_CHAN_OFF   = 4'h4;
	localparam logic [3:0]  FN_HALT       = 4'h5;
	localparam logic [3:0]  SK_READY      = 4'h1;
	localparam logic [3:0]  SK_BUSY       = 4'h2;
	localparam logic [3:0]  SK_INT        = 4'h3;
	localparam logic [3:0]  SK_NOT_BUSY   = 4'h4;

	// ********************************
	// Strobe vector bit positions
	// ********************************
	localparam int STB_OCP  = 0;
	localparam int STB_RRL  = 1;
	localparam int STB_OTP  = 2;
	localparam int STB_SMK  = 3;
	localparam int STB_DIP  = 4;
	localparam int STB_DLP  = 5;
	localparam int STB_ERL  = 6;
	localparam int STB_ACK  = 7;
	localparam int STB_DAL  = 8;
	localparam int STB_SKS  = 9;
	localparam int STB_NORM = 10;
	localparam int STB_W    = 11;

	// Direction flip-flop values
	localparam logic DIR_IN  = 1'b0;
	localparam logic DIR_OUT = 1'b1;

	// Channel sequencer states
	typedef enum logic [1:0] {CH_OFF, CH_IDLE, CH_REQ, CH_XFER} iob_ch_state_t;

	// Register write request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} iob_wreq_t;

endpackage

// ===== design/iob_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/100ps
module iob_sync_edge #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	// Meta stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= d;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Edge pulses from settled stages
	assign q    = sync_r;
	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;
endmodule

// ===== design/iob_axil_slave.sv
// AXI4-Lite slave front end producing register strobes
`timescale 1ns/100ps
module iob_axil_slave (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire logic          s_awvalid,
	output logic               s_awready,
	input  wire logic [7:0]    s_awaddr,
	input  wire logic          s_wvalid,
	output logic               s_wready,
	input  wire logic [31:0]   s_wdata,
	input  wire logic [3:0]    s_wstrb,
	output logic               s_bvalid,
	input  wire logic          s_bready,
	output logic [1:0]         s_bresp,
	input  wire logic          s_arvalid,
	output logic               s_arready,
	input  wire logic [7:0]    s_araddr,
	output logic               s_rvalid,
	input  wire logic          s_rready,
	output logic [31:0]        s_rdata,
	output logic [1:0]         s_rresp,
	output logic               wr_en,
	output iob_pkg::iob_wreq_t wr_req,
	input  wire logic          wr_ok,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_ok
);
	logic aw_held_r;
	logic w_held_r;

	assign s_awready = !aw_held_r && !s_bvalid;
	assign s_wready  = !w_held_r && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign wr_en     = aw_held_r && w_held_r && !s_bvalid;

	// Write address and data captured in either order
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			wr_req    <= '0;
			s_bvalid  <= 1'b0;
			s_bresp   <= iob_pkg::RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held_r   <= 1'b1;
				wr_req.addr <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held_r    <= 1'b1;
				wr_req.data <= s_wdata;
				wr_req.strb <= s_wstrb;
			end
			if (wr_en) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= wr_ok ? iob_pkg::RESP_OKAY : iob_pkg::RESP_DECERR;
			end else if (s_bready) begin
				s_bvalid  <= 1'b0;
			end
		end
	end

	// Read answered one cycle after the address is taken
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_rvalid <= 1'b0;
			s_rdata  <= '0;
			s_rresp  <= iob_pkg::RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
			s_rresp  <= rd_ok ? iob_pkg::RESP_OKAY : iob_pkg::RESP_DECERR;
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
endmodule

// ===== design/iob_device.sv
// Device control interface on the parallel I/O bus
// Summary of operation
// - Decode address and function on control pulses
// - Write-type control sets ready and busy
// - Read-type control sets busy only
// - Direction flip-flop follows control command type
// - Skip test selects ready, busy or interrupt
// - Drive input bus only when addressed
// - Input ready reset clears buffer and ready
// - Output strobe loads output word into buffer
// - Output mode: ready reset spares buffer, clears ready
// - Load pulse trailing edge sets ready again
// - Mask set pulse samples assigned output bit
// - Drop-in loads buffer, sets ready, holds data
// - Interrupt line equals ready and mask, or event flag and mask on no-ready devices
// - Interrupt skip needs mask and ready, or mask and event flag on no-ready devices
// - Normalize clears busy, ready and mask
// - Channel address, when channel enabled, also selects alongside normal address decode
// - Channel enable gates requests; end-of-range stops
// - Out of data raises block stop line
// - No-ready devices clear interrupt on clear strobe
// - Drop channel request once channel address seen
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module iob_device #(
	parameter int ADDR_W = 6,
	parameter int FUNC_W = 4,
	parameter int DATA_W = 16
) (
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [7:0]        s_awaddr,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	output logic [1:0]             s_bresp,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	input  wire logic [7:0]        s_araddr,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	input  wire logic [ADDR_W-1:0] address_bus,
	input  wire logic [FUNC_W-1:0] function_bus,
	input  wire logic [DATA_W-1:0] output_bus,
	input  wire logic              output_control_command,
	input  wire logic              skip_condition_test,
	input  wire logic              ready_reset_pulse,
	input  wire logic              output_strobe_pulse,
	input  wire logic              mask_set_pulse,
	input  wire logic              master_clear_level,
	input  wire logic              power_on_normalize_pulse,
	input  wire logic              channel_address_line,
	input  wire logic              end_of_range_pulse,
	input  wire logic              interrupt_clear_strobe,
	output logic [DATA_W-1:0]      input_bus,
	output logic                   input_bus_oe,
	output logic                   skip_response_line,
	output logic                   program_interrupt_line,
	output logic                   channel_request_line,
	output logic                   block_stop_line,
	output logic                   parity_error_line,
	input  wire logic              device_drop_in_pulse,
	input  wire logic [DATA_W-1:0] drop_in_data,
	input  wire logic              device_load_pulse,
	output logic [DATA_W-1:0]      load_data,
	output logic                   busy_level,
	output logic                   output_mode,
	input  wire logic              data_exhausted,
	input  wire logic              parity_fault
);
	localparam int LVL_W = ADDR_W + FUNC_W + 2 * DATA_W;

	// ********************************
	// Elaboration checks
	// ********************************
	if (DATA_W < 1 || DATA_W > 32 || DATA_W > (1 << iob_pkg::CFG_MBIT_W)) begin : g_bad_data
		$error("DATA_W must lie in 1..16");
	end
	if (ADDR_W < 1 || ADDR_W > 8 || FUNC_W != 4) begin : g_bad_addr
		$error("ADDR_W must lie in 1..8 and FUNC_W must be 4");
	end

	// ********************************
	// Declarations
	// ********************************
	logic [iob_pkg::STB_W-1:0] stb_raw;
	logic [iob_pkg::STB_W-1:0] stb_lvl;
	logic [iob_pkg::STB_W-1:0] stb_rise;
	logic [iob_pkg::STB_W-1:0] stb_fall;
	logic [LVL_W-1:0]          lvl_raw;
	logic [LVL_W-1:0]          lvl_q;
	logic [ADDR_W-1:0]         addr_s;
	logic [FUNC_W-1:0]         func_s;
	logic [DATA_W-1:0]         obus_s;
	logic [DATA_W-1:0]         dip_s;
	logic                      normalize;
	logic                      addr_hit;
	logic                      selected;
	logic                      ocp_hit;
	logic                      int_cond;
	logic                      skip_nxt;
	logic                      dip_take;
	logic                      wr_en;
	iob_pkg::iob_wreq_t        wr_req;
	logic                      wr_ok;
	logic [31:0]               rd_data;
	logic                      rd_ok;
	logic [31:0]               config_r;
	logic [31:0]               status;
	logic                      ready_r;
	logic                      busy_r;
	logic                      mask_r;
	logic                      dir_r;
	logic                      int_flag_r;
	logic                      overrun_r;
	logic                      chan_en_r;
	logic                      chan_ready_r;
	logic [DATA_W-1:0]         buffer_r;
	iob_pkg::iob_ch_state_t    ch_state_r;
	iob_pkg::iob_ch_state_t    ch_state_nxt;

	// Test an address against a register offset
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr[7:2] == off[7:2]);
	endfunction

	// Merge a written word into a register under byte strobes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		merge_bytes = res;
	endfunction

	// ********************************
	// Strobe and bus synchronisation
	// ********************************
	// All host and mechanism strobes enter one synchroniser
	always_comb begin
		stb_raw                    = '0;
		stb_raw[iob_pkg::STB_OCP]  = output_control_command;
		stb_raw[iob_pkg::STB_RRL]  = ready_reset_pulse;
		stb_raw[iob_pkg::STB_OTP]  = output_strobe_pulse;
		stb_raw[iob_pkg::STB_SMK]  = mask_set_pulse;
		stb_raw[iob_pkg::STB_DIP]  = device_drop_in_pulse;
		stb_raw[iob_pkg::STB_DLP]  = device_load_pulse;
		stb_raw[iob_pkg::STB_ERL]  = end_of_range_pulse;
		stb_raw[iob_pkg::STB_ACK]  = interrupt_clear_strobe;
		stb_raw[iob_pkg::STB_DAL]  = channel_address_line;
		stb_raw[iob_pkg::STB_SKS]  = skip_condition_test;
		stb_raw[iob_pkg::STB_NORM] = master_clear_level | power_on_normalize_pulse;
	end

	// Buses share the strobe latency so data lines up
	assign lvl_raw = {address_bus, function_bus, output_bus, drop_in_data};

	// Strobes synchronised before any flip-flop sees them
	iob_sync_edge #(.W(iob_pkg::STB_W)) u_stb_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.d       (stb_raw),
		.q       (stb_lvl),
		.rise    (stb_rise),
		.fall    (stb_fall)
	);

	iob_sync_edge #(.W(LVL_W)) u_lvl_sync (
		.clock   (clock),
		.sys_rst (sys_rst),
		.d       (lvl_raw),
		.q       (lvl_q),
		.rise    (),
		.fall    ()
	);

	assign {addr_s, func_s, obus_s, dip_s} = lvl_q;

	// ********************************
	// Address and function decode
	// ********************************
	assign normalize = stb_lvl[iob_pkg::STB_NORM];
	assign addr_hit  = (addr_s == config_r[iob_pkg::CFG_ADDR_LSB +: ADDR_W]);
	assign selected  = addr_hit | (chan_en_r & stb_lvl[iob_pkg::STB_DAL]);
	assign ocp_hit   = stb_rise[iob_pkg::STB_OCP] & addr_hit;
	assign dip_take  = stb_rise[iob_pkg::STB_DIP] & busy_r & (dir_r == iob_pkg::DIR_IN)
		& !ready_r;
	// Interrupt condition per device kind
	assign int_cond  = config_r[iob_pkg::CFG_NO_READY] ? (int_flag_r & mask_r)
		: (ready_r & mask_r);

	// ********************************
	// Ready flip-flop
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			ready_r <= 1'b0;
		end else if (ocp_hit && func_s == iob_pkg::FN_WRITE) begin
			ready_r <= 1'b1;
		end else if (ocp_hit && (func_s == iob_pkg::FN_READ || func_s == iob_pkg::FN_HALT)) begin
			ready_r <= 1'b0;
		end else if (dip_take) begin
			ready_r <= 1'b1;
		end else if (stb_fall[iob_pkg::STB_DLP] && dir_r == iob_pkg::DIR_OUT && busy_r) begin
			ready_r <= 1'b1;
		end else if (stb_rise[iob_pkg::STB_RRL] && selected && dir_r == iob_pkg::DIR_IN) begin
			ready_r <= 1'b0;
		end else if (stb_fall[iob_pkg::STB_RRL] && selected && dir_r == iob_pkg::DIR_OUT) begin
			ready_r <= 1'b0;
		end
	end

	// ********************************
	// Busy and direction flip-flops
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			busy_r <= 1'b0;
		end else if (ocp_hit && (func_s == iob_pkg::FN_WRITE || func_s == iob_pkg::FN_READ)) begin
			busy_r <= 1'b1;
		end else if (ocp_hit && func_s == iob_pkg::FN_HALT) begin
			busy_r <= 1'b0;
		end
	end

	// Direction held through normalize, set by command type
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dir_r <= iob_pkg::DIR_IN;
		end else if (ocp_hit && func_s == iob_pkg::FN_WRITE) begin
			dir_r <= iob_pkg::DIR_OUT;
		end else if (ocp_hit && func_s == iob_pkg::FN_READ) begin
			dir_r <= iob_pkg::DIR_IN;
		end
	end

	// ********************************
	// Mask and interrupt flag
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			mask_r <= 1'b0;
		end else if (stb_rise[iob_pkg::STB_SMK]) begin
			mask_r <= obus_s[config_r[iob_pkg::CFG_MBIT_LSB +: iob_pkg::CFG_MBIT_W]];
		end
	end

	// Mechanism event flag for devices without ready; set wins
	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			int_flag_r <= 1'b0;
		end else if (stb_rise[iob_pkg::STB_DIP]) begin
			int_flag_r <= 1'b1;
		end else if (stb_rise[iob_pkg::STB_ACK]) begin
			int_flag_r <= 1'b0;
		end
	end

	// ********************************
	// Data buffer
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			buffer_r <= '0;
		end else if (dip_take) begin
			buffer_r <= dip_s;
		end else if (stb_rise[iob_pkg::STB_OTP] && selected && dir_r == iob_pkg::DIR_OUT) begin
			buffer_r <= obus_s;
		end else if (stb_rise[iob_pkg::STB_RRL] && selected && dir_r == iob_pkg::DIR_IN) begin
			buffer_r <= '0;
		end
	end

	// Drop-in refused while data waits; set wins over clear
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overrun_r <= 1'b0;
		end else if (stb_rise[iob_pkg::STB_DIP] && busy_r && dir_r == iob_pkg::DIR_IN && ready_r) begin
			overrun_r <= 1'b1;
		end else if (wr_en && reg_hit(wr_req.addr, iob_pkg::REG_STATUS)
			&& wr_req.strb[0] && wr_req.data[iob_pkg::ST_OVERRUN]) begin
			overrun_r <= 1'b0;
		end
	end

	// ********************************
	// Host-facing outputs
	// ********************************
	// Skip condition selected by function bits
	always_comb begin
		case (func_s)
			iob_pkg::SK_READY:    skip_nxt = ready_r;
			iob_pkg::SK_BUSY:     skip_nxt = busy_r;
			iob_pkg::SK_INT:      skip_nxt = int_cond;
			iob_pkg::SK_NOT_BUSY: skip_nxt = !busy_r;
			default:              skip_nxt = 1'b0;
		endcase
		skip_nxt = skip_nxt & stb_lvl[iob_pkg::STB_SKS] & addr_hit;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			skip_response_line     <= 1'b0;
			program_interrupt_line <= 1'b0;
			input_bus_oe           <= 1'b0;
			parity_error_line      <= 1'b0;
		end else begin
			skip_response_line     <= skip_nxt;
			program_interrupt_line <= int_cond;
			input_bus_oe           <= selected && dir_r == iob_pkg::DIR_IN;
			parity_error_line      <= parity_fault & config_r[iob_pkg::CFG_PARITY_EN];
		end
	end

	assign input_bus   = buffer_r;
	assign load_data   = buffer_r;
	assign busy_level  = busy_r;
	assign output_mode = dir_r;

	// ********************************
	// Direct channel sequencer
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			chan_en_r    <= 1'b0;
			chan_ready_r <= 1'b0;
		end else if (ocp_hit && func_s == iob_pkg::FN_CHAN_ON) begin
			chan_en_r    <= 1'b1;
			chan_ready_r <= 1'b1;
		end else if (ocp_hit && func_s == iob_pkg::FN_CHAN_OFF) begin
			chan_en_r    <= 1'b0;
		end else if (stb_rise[iob_pkg::STB_ERL] && selected) begin
			chan_ready_r <= 1'b0;
		end
	end

	always_comb begin
		ch_state_nxt = ch_state_r;
		case (ch_state_r)
			iob_pkg::CH_OFF: begin
				if (chan_en_r && chan_ready_r) begin
					ch_state_nxt = iob_pkg::CH_IDLE;
				end
			end
			iob_pkg::CH_IDLE: begin
				if (!chan_en_r || !chan_ready_r) begin
					ch_state_nxt = iob_pkg::CH_OFF;
				end else if (ready_r && busy_r) begin
					ch_state_nxt = iob_pkg::CH_REQ;
				end
			end
			iob_pkg::CH_REQ: begin
				if (!chan_en_r || !chan_ready_r) begin
					ch_state_nxt = iob_pkg::CH_OFF;
				end else if (stb_rise[iob_pkg::STB_DAL]) begin
					ch_state_nxt = iob_pkg::CH_XFER;
				end
			end
			iob_pkg::CH_XFER: begin
				if (!stb_lvl[iob_pkg::STB_DAL] && !ready_r) begin
					ch_state_nxt = iob_pkg::CH_IDLE;
				end
			end
			default: ch_state_nxt = iob_pkg::CH_OFF;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst || normalize) begin
			ch_state_r           <= iob_pkg::CH_OFF;
			channel_request_line <= 1'b0;
			block_stop_line      <= 1'b0;
		end else begin
			ch_state_r           <= ch_state_nxt;
			channel_request_line <= (ch_state_nxt == iob_pkg::CH_REQ);
			block_stop_line      <= config_r[iob_pkg::CFG_BLOCK] && chan_en_r
				&& chan_ready_r && busy_r && data_exhausted;
		end
	end

	// ********************************
	// Register file
	// ********************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			config_r <= iob_pkg::CONFIG_RST;
		end else if (wr_en && reg_hit(wr_req.addr, iob_pkg::REG_CONFIG)) begin
			config_r <= merge_bytes(config_r, wr_req.data, wr_req.strb);
		end
	end

	always_comb begin
		status                         = '0;
		status[iob_pkg::ST_READY]      = ready_r;
		status[iob_pkg::ST_BUSY]       = busy_r;
		status[iob_pkg::ST_MASK]       = mask_r;
		status[iob_pkg::ST_DIR]        = dir_r;
		status[iob_pkg::ST_CHAN_EN]    = chan_en_r;
		status[iob_pkg::ST_CHAN_READY] = chan_ready_r;
		status[iob_pkg::ST_INT_FLAG]   = int_flag_r;
		status[iob_pkg::ST_OVERRUN]    = overrun_r;
		status[iob_pkg::ST_CHAN_REQ]   = channel_request_line;
		status[iob_pkg::ST_BLOCK_STOP] = block_stop_line;
	end

	// Read decode; unmapped offsets answer with a decode error
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = '0;
		if (reg_hit(s_araddr, iob_pkg::REG_CONFIG)) begin
			rd_data = config_r;
		end else if (reg_hit(s_araddr, iob_pkg::REG_STATUS)) begin
			rd_data = status;
		end else if (reg_hit(s_araddr, iob_pkg::REG_BUFFER)) begin
			rd_data = 32'(buffer_r);
		end else begin
			rd_ok = 1'b0;
		end
	end

	assign wr_ok = reg_hit(wr_req.addr, iob_pkg::REG_CONFIG)
		|| reg_hit(wr_req.addr, iob_pkg::REG_STATUS)
		|| reg_hit(wr_req.addr, iob_pkg::REG_BUFFER);

	iob_axil_slave u_axil (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_awaddr  (s_awaddr),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_bresp   (s_bresp),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_araddr  (s_araddr),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.wr_en     (wr_en),
		.wr_req    (wr_req),
		.wr_ok     (wr_ok),
		.rd_data   (rd_data),
		.rd_ok     (rd_ok)
	);
endmodule

// ===== sim/iob_device_checker.sv
// Port checker for the I/O bus device interface
`timescale 1ns/100ps
module iob_device_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic master_clear_level,
	input wire logic output_control_command,
	input wire logic skip_condition_test,
	input wire logic busy_level,
	input wire logic output_mode,
	input wire logic input_bus_oe,
	input wire logic skip_response_line,
	input wire logic program_interrupt_line
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	norm_busy_a: assert property (master_clear_level [*5] |-> !busy_level)
		else $error("busy kept through clear");
	norm_int_a: assert property (master_clear_level [*6] |-> !program_interrupt_line)
		else $error("interrupt kept through clear");
	busy_cause_a: assert property (
		$rose(busy_level) |-> $past(output_control_command, 3))
		else $error("busy rose without control");
	dir_cause_a: assert property (
		$changed(output_mode) |-> $past(output_control_command, 3))
		else $error("direction moved without control");
	skip_cause_a: assert property (
		skip_response_line |-> $past(skip_condition_test, 3) || $past(skip_condition_test, 4))
		else $error("skip without test");
	skip_idle_a: assert property (!skip_condition_test [*6] |-> !skip_response_line)
		else $error("skip while idle");
	oe_dir_a: assert property (input_bus_oe |-> !$past(output_mode))
		else $error("input bus driven in output mode");
	int_busy_a: assert property ($rose(program_interrupt_line) |-> busy_level)
		else $error("interrupt while idle");
	cover property (program_interrupt_line);
	cover property (skip_response_line);
	cover property (input_bus_oe);
endmodule

bind iob_device iob_device_checker iob_chk_inst (.*);

// ===== sim/iob_host.sv
// Host computer model driving the parallel I/O bus
`timescale 1ns/100ps
module iob_host (
	input  wire logic        clock,
	input  wire logic        skip,
	input  wire logic [15:0] inb,
	output logic      [5:0]  adr,
	output logic      [3:0]  fn,
	output logic      [15:0] ob,
	output logic      [10:0] stb
);
	// Quiet bus at time zero
	initial begin
		{adr, fn, ob, stb} = 37'h0;
	end
	// One strobe; buses settle before it and outlast it
	task automatic pulse(input int s, input logic [5:0] a, input logic [3:0] f,
		input logic [15:0] d, output logic r, output logic [15:0] di);
		@(posedge clock);
		{adr, fn, ob} <= {a, f, d};
		repeat (5) @(posedge clock);
		stb[s] <= 1'b1;
		@(negedge clock);
		di = inb;
		repeat (6) @(negedge clock);
		r = skip;
		@(posedge clock);
		stb[s] <= 1'b0;
		repeat (5) @(posedge clock);
		{adr, fn, ob} <= ~{a, f, d}; // Released lines drop the old value
		@(negedge clock);
	endtask
	// Input instruction: ready test, then data only when ready
	task automatic input_to_accumulator(input logic [5:0] a, output logic ok, output logic [15:0] di);
		logic x;
		pulse(9, a, iob_pkg::SK_READY, 16'h0000, ok, di);
		if (ok === 1'b1) begin
			pulse(1, a, 4'h0, 16'h0000, x, di);
		end
	endtask
endmodule

// ===== sim/iob_device_tb.sv
// Self-checking bench for the I/O bus device interface
`timescale 1ns/100ps
module iob_device_tb;
	localparam logic [5:0] A = 6'h01; // Device address after reset
	localparam logic [3:0] SR = iob_pkg::SK_READY;
	logic        clock, sys_rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready, input_bus_oe, skip_response_line;
	logic        program_interrupt_line, channel_request_line, busy_level, output_mode, r, ok;
	logic [1:0]  s_bresp, s_rresp, rs;
	logic [3:0]  s_wstrb, fn;
	logic [5:0]  adr;
	logic [7:0]  s_awaddr, s_araddr;
	logic [10:0] stb;
	logic [15:0] input_bus, load_data, drop_in_data, ob, di;
	logic [31:0] s_wdata, s_rdata, d;
	int          error_cnt = 0;
	int          tests_run = 0;
	iob_device iob_device_inst (.address_bus(adr), .function_bus(fn), .output_bus(ob),
		.output_control_command(stb[0]), .ready_reset_pulse(stb[1]), .output_strobe_pulse(stb[2]),
		.mask_set_pulse(stb[3]), .device_drop_in_pulse(stb[4]), .device_load_pulse(stb[5]),
		.end_of_range_pulse(stb[6]), .interrupt_clear_strobe(stb[7]),
		.channel_address_line(stb[8]), .skip_condition_test(stb[9]), .master_clear_level(stb[10]),
		.power_on_normalize_pulse(1'b0), .data_exhausted(1'b0), .parity_fault(1'b0),
		.block_stop_line(), .parity_error_line(), .*);
	iob_host iob_host_inst (.clock(clock), .skip(skip_response_line), .inb(input_bus),
		.adr(adr), .fn(fn), .ob(ob), .stb(stb));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// Bus tasks
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic aw, w, b;
		@(posedge clock);
		{s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, v, 3'h7};
		do begin
			@(negedge clock);
			{aw, w, b, rs} = {s_awready, s_wready, s_bvalid, s_bresp};
			@(posedge clock);
			if (aw) s_awvalid <= 1'b0;
			if (w) s_wvalid <= 1'b0;
			if (b) s_bready <= 1'b0;
		end while (b !== 1'b1);
	endtask
	task automatic axr(input logic [7:0] a);
		logic ar, v;
		@(posedge clock);
		{s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
		do begin
			@(negedge clock);
			{ar, v, d, rs} = {s_arready, s_rvalid, s_rdata, s_rresp};
			@(posedge clock);
			if (ar) s_arvalid <= 1'b0;
			if (v) s_rready <= 1'b0;
		end while (v !== 1'b1);
	endtask
	task automatic p(input int s, input logic [5:0] a, input logic [3:0] f,
		input logic [15:0] v = 16'h0000);
		iob_host_inst.pulse(s, a, f, v, r, di);
	endtask
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// Scenarios
	task automatic t_regs();
		axr(8'h00);
		chk("config", d, 32'h0000_0001);
		axw(8'h00, 32'h0000_0101);
		chk("bresp", rs, 2'h0);
		axr(8'h0c);
		chk("decerr", rs, 2'h3);
	endtask
	task automatic t_out();
		p(0, A, iob_pkg::FN_WRITE);
		chk("busy", busy_level, 1'b1);
		chk("dir", output_mode, 1'b1);
		p(2, A, 4'h0, 16'h5a3c);
		chk("load", load_data, 16'h5a3c);
		p(1, A, 4'h0);
		p(9, A, SR);
		chk("ready", r, 1'b0);
		chk("kept", load_data, 16'h5a3c);
		p(5, A, 4'h0);
		p(9, A, SR);
		chk("ready", r, 1'b1);
	endtask
	task automatic t_in();
		p(0, A, iob_pkg::FN_READ);
		chk("dir", output_mode, 1'b0);
		iob_host_inst.input_to_accumulator(A, ok, di);
		chk("early", ok, 1'b0);
		p(3, A, 4'h0, 16'h0002);
		p(4, A, 4'h0);
		chk("pil", program_interrupt_line, 1'b1);
		p(9, 6'h02, SR);
		chk("foreign", r, 1'b0);
		p(9, A, iob_pkg::SK_INT);
		chk("skint", r, 1'b1);
		iob_host_inst.input_to_accumulator(A, ok, di);
		chk("data", di, 16'hc35a);
		chk("clear", load_data, 16'h0000);
		chk("pil", program_interrupt_line, 1'b0);
		p(10, A, 4'h0);
		chk("busy", busy_level, 1'b0);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#40000;
		error_cnt++;
		complete_run();
	end
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wdata, drop_in_data} = 64'hc35a;
		s_wstrb = 4'hf;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		t_regs();
		t_out();
		t_in();
		complete_run();
	end
endmodule
